// *** core/ddrcr_pkg.sv ***
package ddrcr_pkg;

    // ****************************************************************
    // Command encodings on {rowStrobeN, colStrobeN, writeEnN}
    // ****************************************************************
    typedef enum logic [3:0] {
        CMD_NOP      = 4'h0,
        CMD_ACTIVATE = 4'h1,
        CMD_READ     = 4'h2,
        CMD_WRITE    = 4'h3,
        CMD_TRUNCATE = 4'h4,
        CMD_PRECHG   = 4'h5,
        CMD_REFRESH  = 4'h6,
        CMD_MODELOAD = 4'h7,
        CMD_SELFREF  = 4'h8
    } ddrcr_cmd_t;

    localparam logic [2:0] ENC_NOP      = 3'h7;
    localparam logic [2:0] ENC_ACTIVATE = 3'h3;
    localparam logic [2:0] ENC_READ     = 3'h5;
    localparam logic [2:0] ENC_WRITE    = 3'h4;
    localparam logic [2:0] ENC_TRUNCATE = 3'h6;
    localparam logic [2:0] ENC_PRECHG   = 3'h2;
    localparam logic [2:0] ENC_REFRESH  = 3'h1;
    localparam logic [2:0] ENC_MODELOAD = 3'h0;

    // ****************************************************************
    // Field positions, widths, timing
    // ****************************************************************
    localparam int AP_BIT        = 10;
    localparam int ADDR_W        = 13;
    localparam int BANK_W        = 2;
    localparam int NUM_BANKS     = 4;
    localparam logic [1:0] BANK_BASE_MODE = 2'h0;
    localparam logic [1:0] BANK_EXT_MODE  = 2'h1;
    localparam int DLL_LOCK_CYCLES = 200;
    localparam int BURST_LEN_DEF   = 4;
    localparam int PRECHG_CYC_DEF  = 2;
    localparam int REF_ROWS_W      = 13;

    // Device states
    typedef enum logic [1:0] {
        ST_NORMAL  = 2'h0,
        ST_SELFREF = 2'h1,
        ST_EXIT    = 2'h2
    } ddrcr_state_t;

endpackage

// *** core/ddrcr_core.sv ***
`timescale 1ns/1ps
module ddrcr_core #(
    parameter int COL_W      = 10,
    parameter int DATA_W     = 8,
    parameter int BURST_LEN  = ddrcr_pkg::BURST_LEN_DEF,
    parameter int PRECHG_CYC = ddrcr_pkg::PRECHG_CYC_DEF,
    parameter int SELF_REF_PERIOD = 780
) (
    input  wire logic                            clk,
    input  wire logic                            nrst,
    input  wire logic                            clkEn,
    input  wire logic                            chipSelN,
    input  wire logic                            rowStrobeN,
    input  wire logic                            colStrobeN,
    input  wire logic                            writeEnN,
    input  wire logic [ddrcr_pkg::BANK_W-1:0]    bankAddr,
    input  wire logic [ddrcr_pkg::ADDR_W-1:0]    addr,
    input  wire logic [DATA_W-1:0]               wrData,
    input  wire logic                            wrMask,
    input  wire logic                            wrDataValid,
    output logic      [3:0]                      cmdCode,
    output logic      [ddrcr_pkg::NUM_BANKS-1:0] bankOpen,
    output logic      [ddrcr_pkg::ADDR_W-1:0]    openRow0,
    output logic      [ddrcr_pkg::ADDR_W-1:0]    baseModeReg,
    output logic      [ddrcr_pkg::ADDR_W-1:0]    extModeReg,
    output logic                                 burstActive,
    output logic                                 burstIsRead,
    output logic      [ddrcr_pkg::BANK_W-1:0]    burstBank,
    output logic      [COL_W-1:0]                burstCol,
    output logic                                 arrayWrite,
    output logic      [DATA_W-1:0]               arrayData,
    output logic      [ddrcr_pkg::REF_ROWS_W-1:0] refreshRow,
    output logic                                 refreshPulse,
    output logic                                 selfRefresh,
    output logic                                 dllEnabled,
    output logic                                 readAllowed
);

    // ****************************************************************
    // Command decode
    // ****************************************************************
    ddrcr_pkg::ddrcr_cmd_t cmd;
    ddrcr_pkg::ddrcr_state_t state;
    logic [7:0]  exitCount;
    logic [3:0]  beatCount;
    logic        burstAp;
    logic [1:0]  pchBank;
    logic [3:0]  pchCount;
    logic        pchPending;
    logic [15:0] srTimer;

    always_comb begin
        cmd = ddrcr_pkg::CMD_NOP;
        if (state == ddrcr_pkg::ST_NORMAL && !chipSelN) begin
            case ({rowStrobeN, colStrobeN, writeEnN})
                ddrcr_pkg::ENC_ACTIVATE: cmd = ddrcr_pkg::CMD_ACTIVATE;
                ddrcr_pkg::ENC_READ:     cmd = ddrcr_pkg::CMD_READ;
                ddrcr_pkg::ENC_WRITE:    cmd = ddrcr_pkg::CMD_WRITE;
                ddrcr_pkg::ENC_TRUNCATE: cmd = ddrcr_pkg::CMD_TRUNCATE;
                ddrcr_pkg::ENC_PRECHG:   cmd = ddrcr_pkg::CMD_PRECHG;
                ddrcr_pkg::ENC_REFRESH: begin
                    if (clkEn) cmd = ddrcr_pkg::CMD_REFRESH;
                    else cmd = ddrcr_pkg::CMD_SELFREF;
                end
                ddrcr_pkg::ENC_MODELOAD: cmd = ddrcr_pkg::CMD_MODELOAD;
                default:                 cmd = ddrcr_pkg::CMD_NOP;
            endcase
        end
    end

    // Registered decoded command for observation
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmdCode <= 4'h0;
        end else begin
            cmdCode <= cmd;
        end
    end

    // ****************************************************************
    // Mode registers
    // ****************************************************************
    // mode load target select
    always_ff @(posedge clk) begin
        if (!nrst) begin
            baseModeReg <= 13'h0000;
            extModeReg  <= 13'h0000;
        end else if (cmd == ddrcr_pkg::CMD_MODELOAD) begin
            if (bankAddr == ddrcr_pkg::BANK_BASE_MODE) begin
                baseModeReg <= addr;
            end else if (bankAddr == ddrcr_pkg::BANK_EXT_MODE) begin
                extModeReg <= addr;
            end
        end
    end

    // ****************************************************************
    // Bank state: activate, precharge, auto precharge
    // ****************************************************************
    logic apDone;
    assign apDone = pchPending && (pchCount == 4'h0);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bankOpen <= 4'h0;
            openRow0 <= 13'h0000;
        end else begin
            if (cmd == ddrcr_pkg::CMD_ACTIVATE) begin
                bankOpen[bankAddr] <= 1'b1;
                if (bankAddr == 2'h0) begin
                    openRow0 <= addr;
                end
            end
            if (cmd == ddrcr_pkg::CMD_PRECHG) begin
                if (addr[ddrcr_pkg::AP_BIT]) begin
                    bankOpen <= 4'h0;
                end else begin
                    bankOpen[bankAddr] <= 1'b0;
                end
            end
            if (apDone) begin
                bankOpen[pchBank] <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Burst tracking
    // ****************************************************************
    // auto precharge latched per command
    always_ff @(posedge clk) begin
        if (!nrst) begin
            burstActive <= 1'b0;
            burstIsRead <= 1'b0;
            burstAp     <= 1'b0;
            burstBank   <= 2'h0;
            burstCol    <= '0;
            beatCount   <= 4'h0;
        end else if (cmd == ddrcr_pkg::CMD_READ || cmd == ddrcr_pkg::CMD_WRITE) begin
            burstActive <= 1'b1;
            burstIsRead <= (cmd == ddrcr_pkg::CMD_READ);
            burstAp     <= addr[ddrcr_pkg::AP_BIT];
            burstBank   <= bankAddr;
            burstCol    <= addr[COL_W-1:0];
            beatCount   <= 4'((BURST_LEN / 2) - 1);
        end else if (cmd == ddrcr_pkg::CMD_TRUNCATE && burstIsRead) begin
            burstActive <= 1'b0;
        end else if (burstActive) begin
            if (beatCount == 4'h0) begin
                burstActive <= 1'b0;
            end else begin
                beatCount <= beatCount - 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pchPending <= 1'b0;
            pchBank    <= 2'h0;
            pchCount   <= 4'h0;
        end else if (burstActive && burstAp && beatCount == 4'h0) begin
            pchPending <= 1'b1;
            pchBank    <= burstBank;
            pchCount   <= 4'(PRECHG_CYC - 1);
        end else if (pchPending) begin
            if (pchCount == 4'h0) begin
                pchPending <= 1'b0;
            end else begin
                pchCount <= pchCount - 4'h1;
            end
        end
    end

    // ****************************************************************
    // Write data with mask
    // ****************************************************************
    // mask high inhibits write
    always_ff @(posedge clk) begin
        if (!nrst) begin
            arrayWrite <= 1'b0;
            arrayData  <= '0;
        end else begin
            arrayWrite <= wrDataValid && !wrMask && burstActive && !burstIsRead;
            arrayData  <= wrData;
        end
    end

    // ****************************************************************
    // Refresh and self refresh
    // ****************************************************************
    // self refresh state machine
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state     <= ddrcr_pkg::ST_NORMAL;
            exitCount <= 8'h00;
        end else begin
            case (state)
                ddrcr_pkg::ST_NORMAL: begin
                    if (cmd == ddrcr_pkg::CMD_SELFREF) begin
                        state <= ddrcr_pkg::ST_SELFREF;
                    end
                end
                ddrcr_pkg::ST_SELFREF: begin
                    if (clkEn) begin
                        state     <= ddrcr_pkg::ST_EXIT;
                        exitCount <= 8'(ddrcr_pkg::DLL_LOCK_CYCLES - 1);
                    end
                end
                ddrcr_pkg::ST_EXIT: begin
                    if (exitCount == 8'h00) begin
                        state <= ddrcr_pkg::ST_NORMAL;
                    end else begin
                        exitCount <= exitCount - 8'h01;
                    end
                end
                default: state <= ddrcr_pkg::ST_NORMAL;
            endcase
        end
    end

    assign selfRefresh = (state == ddrcr_pkg::ST_SELFREF);
    assign dllEnabled  = (state != ddrcr_pkg::ST_SELFREF);
    assign readAllowed = (state == ddrcr_pkg::ST_NORMAL);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            refreshRow   <= 13'h0000;
            refreshPulse <= 1'b0;
            srTimer      <= 16'h0000;
        end else begin
            refreshPulse <= 1'b0;
            if (cmd == ddrcr_pkg::CMD_REFRESH || cmd == ddrcr_pkg::CMD_SELFREF) begin
                refreshRow   <= refreshRow + 13'h0001;
                refreshPulse <= 1'b1;
                srTimer      <= 16'h0000;
            end else if (selfRefresh) begin
                if (srTimer == 16'(SELF_REF_PERIOD - 1)) begin
                    srTimer      <= 16'h0000;
                    refreshRow   <= refreshRow + 13'h0001;
                    refreshPulse <= 1'b1;
                end else begin
                    srTimer <= srTimer + 16'h0001;
                end
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // read blocked for 200 cycles after self refresh exit starts, first 8 checked
    AST_EXIT_WAIT: assert property (@(posedge clk) disable iff (!nrst)
        (state == ddrcr_pkg::ST_SELFREF && clkEn) |=> !readAllowed [*8])
        else $error("read allowed too soon after self refresh exit");
    AST_SR_ENTRY: assert property (@(posedge clk) disable iff (!nrst)
        (state == ddrcr_pkg::ST_NORMAL && !chipSelN && !rowStrobeN && !colStrobeN
         && writeEnN && !clkEn) |=> selfRefresh)
        else $error("self refresh not entered");
    AST_REF_STEP: assert property (@(posedge clk) disable iff (!nrst)
        (cmd == ddrcr_pkg::CMD_REFRESH) |=> refreshRow == $past(refreshRow) + 13'h0001)
        else $error("refresh counter did not advance");
    AST_PRE_ALL: assert property (@(posedge clk) disable iff (!nrst)
        (cmd == ddrcr_pkg::CMD_PRECHG && addr[ddrcr_pkg::AP_BIT] && !apDone) |=> bankOpen == 4'h0)
        else $error("all bank precharge left a bank open");
    AST_ACT_OPEN: assert property (@(posedge clk) disable iff (!nrst)
        (cmd == ddrcr_pkg::CMD_ACTIVATE) |=> bankOpen[$past(bankAddr)])
        else $error("activate did not open bank");
    AST_MASK: assert property (@(posedge clk) disable iff (!nrst)
        (wrMask) |=> !arrayWrite)
        else $error("masked data written");
    AST_DESEL: assert property (@(posedge clk) disable iff (!nrst)
        (chipSelN) |=> $stable(baseModeReg) && $stable(extModeReg))
        else $error("deselect altered a mode register");
    // auto precharge closes bank after burst
    AST_AP_CLOSE: assert property (@(posedge clk) disable iff (!nrst)
        (burstActive && burstAp && beatCount == 4'h0 && cmd == ddrcr_pkg::CMD_NOP)
        |=> pchPending)
        else $error("auto precharge not started at burst end");
    AST_TRUNC: assert property (@(posedge clk) disable iff (!nrst)
        (cmd == ddrcr_pkg::CMD_TRUNCATE && burstIsRead) |=> !burstActive)
        else $error("burst truncate ignored");

endmodule // ddrcr_core

// *** test/ddrcr_ctrl_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Memory controller model driving command, address and write data
// ****************************************************************
module ddrcr_ctrl_model (
    input  wire logic        clk,
    output logic             clkEn,
    output logic             chipSelN,
    output logic             rowStrobeN,
    output logic             colStrobeN,
    output logic             writeEnN,
    output logic [1:0]       bankAddr,
    output logic [12:0]      addr,
    output logic [7:0]       wrData,
    output logic             wrMask,
    output logic             wrDataValid
);
    // Idle pins from time zero
    initial begin
        {clkEn, chipSelN, rowStrobeN, colStrobeN, writeEnN} = 5'h1F;
        {bankAddr, addr} = 15'h0000;
        {wrData, wrMask, wrDataValid} = 10'h000;
    end
    // one command per call, CKE high except at self refresh entry and while in self refresh
    task automatic cmd(input logic [2:0] enc, input logic [1:0] bank,
                       input logic [12:0] a, input logic cke, input logic csN);
        @(negedge clk);
        clkEn = cke;
        chipSelN = csN;
        {rowStrobeN, colStrobeN, writeEnN} = enc;
        bankAddr = bank;
        addr = a;
    endtask
    // deselect, released address lines show the inverse value
    task automatic idle();
        @(negedge clk);
        {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'hF;
        addr = ~addr;
        bankAddr = ~bankAddr;
    endtask
    // one write element per cycle with its mask, command deselected
    task automatic put_data(input logic [7:0] d, input logic m, input logic v);
        @(negedge clk);
        chipSelN = 1'b1;
        wrData = v ? d : ~wrData;
        wrMask = m;
        wrDataValid = v;
    endtask
    // stable clock kept running, CKE raised to leave self refresh
    task automatic set_cke(input logic v);
        @(negedge clk);
        clkEn = v;
    endtask
endmodule // ddrcr_ctrl_model

// *** test/testbench.sv ***
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
    localparam int BL = 8;
    localparam int PC = 2;
    logic clk, nrst, clkEn, chipSelN, rowStrobeN, colStrobeN, writeEnN, wrMask, wrDataValid;
    logic burstActive, burstIsRead, arrayWrite, refreshPulse, selfRefresh, dllEnabled;
    logic readAllowed;
    logic [1:0]  bankAddr, burstBank;
    logic [12:0] addr, openRow0, baseModeReg, extModeReg, refreshRow, r0;
    logic [7:0]  wrData, arrayData, lastData;
    logic [3:0]  cmdCode, bankOpen;
    logic [9:0]  burstCol;
    int num_errors = 0, check_count = 0, refCnt = 0, wrCnt = 0, p0;

    // ****************************************************************
    // Clock, design, partner and pulse monitor
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ddrcr_core #(.BURST_LEN(BL), .PRECHG_CYC(PC), .SELF_REF_PERIOD(4)) u_dut (
        .clk(clk), .nrst(nrst), .clkEn(clkEn), .chipSelN(chipSelN),
        .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeEnN(writeEnN),
        .bankAddr(bankAddr), .addr(addr), .wrData(wrData), .wrMask(wrMask),
        .wrDataValid(wrDataValid), .cmdCode(cmdCode), .bankOpen(bankOpen),
        .openRow0(openRow0), .baseModeReg(baseModeReg), .extModeReg(extModeReg),
        .burstActive(burstActive), .burstIsRead(burstIsRead), .burstBank(burstBank),
        .burstCol(burstCol), .arrayWrite(arrayWrite), .arrayData(arrayData),
        .refreshRow(refreshRow), .refreshPulse(refreshPulse), .selfRefresh(selfRefresh),
        .dllEnabled(dllEnabled), .readAllowed(readAllowed));
    ddrcr_ctrl_model u_ctrl (
        .clk(clk), .clkEn(clkEn), .chipSelN(chipSelN), .rowStrobeN(rowStrobeN),
        .colStrobeN(colStrobeN), .writeEnN(writeEnN), .bankAddr(bankAddr), .addr(addr),
        .wrData(wrData), .wrMask(wrMask), .wrDataValid(wrDataValid));
    // Counts refresh and array write pulses
    always @(posedge clk) begin
        if (refreshPulse === 1'b1) refCnt <= refCnt + 1;
        if (arrayWrite === 1'b1) begin
            wrCnt <= wrCnt + 1;
            lastData <= arrayData;
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic dec(input logic [2:0] enc, input logic csN, input logic [3:0] exp);
        u_ctrl.cmd(enc, 2'h0, 13'h0000, 1'b1, csN);
        u_ctrl.idle();
        `CHK("cmdCode", exp, cmdCode)
    endtask
    task automatic t_decode();
        dec(ddrcr_pkg::ENC_ACTIVATE, 1'b1, 4'(ddrcr_pkg::CMD_NOP));
        `CHK("bankOpen", 4'h0, bankOpen)
        dec(ddrcr_pkg::ENC_NOP, 1'b0, 4'(ddrcr_pkg::CMD_NOP));
        dec(ddrcr_pkg::ENC_ACTIVATE, 1'b0, 4'(ddrcr_pkg::CMD_ACTIVATE));
        dec(ddrcr_pkg::ENC_READ, 1'b0, 4'(ddrcr_pkg::CMD_READ));
        dec(ddrcr_pkg::ENC_TRUNCATE, 1'b0, 4'(ddrcr_pkg::CMD_TRUNCATE));
        dec(ddrcr_pkg::ENC_WRITE, 1'b0, 4'(ddrcr_pkg::CMD_WRITE));
        dec(ddrcr_pkg::ENC_PRECHG, 1'b0, 4'(ddrcr_pkg::CMD_PRECHG));
        dec(ddrcr_pkg::ENC_REFRESH, 1'b0, 4'(ddrcr_pkg::CMD_REFRESH));
        dec(ddrcr_pkg::ENC_MODELOAD, 1'b0, 4'(ddrcr_pkg::CMD_MODELOAD));
    endtask
    task automatic t_rowmode();
        u_ctrl.cmd(ddrcr_pkg::ENC_ACTIVATE, 2'h0, 13'h1ABC, 1'b1, 1'b0);
        u_ctrl.cmd(ddrcr_pkg::ENC_MODELOAD, 2'h0, 13'h0123, 1'b1, 1'b0);
        u_ctrl.cmd(ddrcr_pkg::ENC_MODELOAD, 2'h1, 13'h0456, 1'b1, 1'b0);
        u_ctrl.cmd(ddrcr_pkg::ENC_MODELOAD, 2'h2, 13'h1FFF, 1'b1, 1'b0);
        u_ctrl.idle();
        `CHK("openRow0", 13'h1ABC, openRow0)
        `CHK("bankOpen0", 1'b1, bankOpen[0])
        `CHK("baseModeReg", 13'h0123, baseModeReg)
        `CHK("extModeReg", 13'h0456, extModeReg)
    endtask
    task automatic t_burst();
        u_ctrl.cmd(ddrcr_pkg::ENC_ACTIVATE, 2'h1, 13'h0042, 1'b1, 1'b0);
        u_ctrl.cmd(ddrcr_pkg::ENC_READ, 2'h1, 13'h0555, 1'b1, 1'b0);
        u_ctrl.idle();
        `CHK("burstActive", 1'b1, burstActive)
        `CHK("burstIsRead", 1'b1, burstIsRead)
        `CHK("burstBank", 2'h1, burstBank)
        `CHK("burstCol", 10'h155, burstCol)
        `CHK("bankOpen1 early", 1'b1, bankOpen[1])
        cyc(BL / 2 + PC - 1);
        `CHK("bankOpen1 before close", 1'b1, bankOpen[1])
        cyc(1);
        `CHK("bankOpen1 closed", 1'b0, bankOpen[1])
        u_ctrl.cmd(ddrcr_pkg::ENC_ACTIVATE, 2'h2, 13'h0077, 1'b1, 1'b0);
        u_ctrl.cmd(ddrcr_pkg::ENC_READ, 2'h2, 13'h0033, 1'b1, 1'b0);
        u_ctrl.idle();
        cyc(BL / 2 + PC + 2);
        `CHK("bankOpen2 kept", 1'b1, bankOpen[2])
        u_ctrl.cmd(ddrcr_pkg::ENC_READ, 2'h2, 13'h0010, 1'b1, 1'b0);
        u_ctrl.cmd(ddrcr_pkg::ENC_TRUNCATE, 2'h3, 13'h1400, 1'b1, 1'b0);
        u_ctrl.idle();
        cyc(1);
        `CHK("burst truncated", 1'b0, burstActive)
        `CHK("bankOpen2 after", 1'b1, bankOpen[2])
    endtask
    task automatic t_prech();
        u_ctrl.cmd(ddrcr_pkg::ENC_ACTIVATE, 2'h3, 13'h0101, 1'b1, 1'b0);
        u_ctrl.cmd(ddrcr_pkg::ENC_PRECHG, 2'h3, 13'h0000, 1'b1, 1'b0);
        u_ctrl.idle();
        `CHK("bankOpen one", 4'h5, bankOpen)
        u_ctrl.cmd(ddrcr_pkg::ENC_PRECHG, 2'h1, 13'h0400, 1'b1, 1'b0);
        u_ctrl.idle();
        `CHK("bankOpen all", 4'h0, bankOpen)
    endtask
    task automatic t_mask();
        u_ctrl.cmd(ddrcr_pkg::ENC_ACTIVATE, 2'h0, 13'h0200, 1'b1, 1'b0);
        u_ctrl.cmd(ddrcr_pkg::ENC_WRITE, 2'h0, 13'h0020, 1'b1, 1'b0);
        p0 = wrCnt;
        u_ctrl.put_data(8'h5A, 1'b0, 1'b1);
        u_ctrl.put_data(8'hA5, 1'b1, 1'b1);
        u_ctrl.put_data(8'h3C, 1'b0, 1'b1);
        u_ctrl.put_data(8'hC3, 1'b1, 1'b1);
        u_ctrl.put_data(8'h00, 1'b0, 1'b0);
        cyc(3);
        `CHK("write count", 2, wrCnt - p0)
        `CHK("arrayData", 8'h3C, lastData)
    endtask
    task automatic t_refresh();
        p0 = refCnt;
        r0 = refreshRow;
        u_ctrl.cmd(ddrcr_pkg::ENC_REFRESH, 2'h3, 13'h1FFF, 1'b1, 1'b0);
        u_ctrl.idle();
        cyc(2);
        `CHK("auto pulses", 1, refCnt - p0)
        `CHK("refreshRow", r0 + 13'h0001, refreshRow)
        `CHK("selfRefresh", 1'b0, selfRefresh)
    endtask
    task automatic t_selfref();
        p0 = refCnt;
        r0 = refreshRow;
        u_ctrl.cmd(ddrcr_pkg::ENC_REFRESH, 2'h0, 13'h0000, 1'b0, 1'b0);
        u_ctrl.idle();
        `CHK("cmdCode", 4'(ddrcr_pkg::CMD_SELFREF), cmdCode)
        `CHK("selfRefresh", 1'b1, selfRefresh)
        `CHK("dllEnabled", 1'b0, dllEnabled)
        u_ctrl.cmd(ddrcr_pkg::ENC_ACTIVATE, 2'h0, 13'h0777, 1'b0, 1'b0);
        u_ctrl.idle();
        cyc(20);
        `CHK("openRow0 kept", 13'h0200, openRow0)
        `CHK("bankOpen kept", 4'h1, bankOpen)
        `CHK("self pulses", 1'b1, (refCnt - p0) >= 4)
        `CHK("row advance", 13'(refCnt - p0), refreshRow - r0)
        u_ctrl.set_cke(1'b1);
        cyc(2);
        `CHK("dll back", 1'b1, dllEnabled)
        `CHK("read blocked", 1'b0, readAllowed)
        u_ctrl.cmd(ddrcr_pkg::ENC_ACTIVATE, 2'h1, 13'h0011, 1'b1, 1'b0);
        u_ctrl.idle();
        `CHK("exit refused", 1'b0, bankOpen[1])
        cyc(ddrcr_pkg::DLL_LOCK_CYCLES - 4);
        `CHK("read still blocked", 1'b0, readAllowed)
        cyc(1);
        `CHK("read allowed", 1'b1, readAllowed)
    endtask

    // ****************************************************************
    // Sequence, watchdog and verdict
    // ****************************************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        cyc(4);
        nrst = 1'b1;
        `CHK("reset bankOpen", 4'h0, bankOpen)
        `CHK("reset dll", 1'b1, dllEnabled)
        `CHK("reset readAllowed", 1'b1, readAllowed)
        t_decode();
        t_rowmode();
        t_burst();
        t_prech();
        t_mask();
        t_refresh();
        t_selfref();
        print_verdict();
    end
    // Cuts a hang short
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule // testbench
